// ---- qft_queue_flags.sv ----
// four-queue flag timing: word counts, standard and fall-through flags
// assumes writer and reader logic run on CLK; storage sits outside
//
// Operation
// R01 - mode strap latched in reset picks standard or fall-through for all queues
// R02 - standard mode: reader requests every word with read enable
// R03 - fall-through: first word presented after three clocks without read select
// R04 - fall-through: later words need read select per clock
// R05 - standard mode: write needs write enable and write select low
// R06 - standard: empty flag rises three clocks after first write
// R07 - standard: almost-empty rises at n+1 words
// R08 - standard: almost-full falls at depth minus m words
// R09 - standard: full flag falls at depth, writes then ignored
// R10 - standard: first read of full queue raises full flag two clocks later
// R11 - draining raises almost-full at threshold, drops almost-empty at n (at n+1 in fall-through)
// R12 - standard: empty flag falls on last read, reads ignored when empty
// R13 - standard: empty and full flags double registered, both data rates
// R14 - fall-through: write select alone writes, output-ready falls after first
// R15 - fall-through: almost-empty rises at n+2 words
// R16 - fall-through: almost-full falls at depth plus one minus m
// R17 - fall-through: input-ready falls at depth plus one, writes ignored
// R18 - fall-through: first read of full queue raises input-ready two clocks later
// R19 - fall-through: output-ready rises after last read, reads ignored when empty
// R20 - fall-through: output-ready triple registered, input-ready double
// R21 - offset select gives n and m of 7, 63, 127 or 1023
// R22 - write controls sampled on rising clock edge only
// R23 - write and read paths have two pipeline stages
// R24 - independent counts and flags per queue, depth from latched width
// R25 - master reset empties queues and sets empty flag state
`default_nettype none

module qft_queue_flags #(
  parameter logic [qft_pkg::CNT_W-1:0] BASE_DEPTH = qft_pkg::BASE_DEPTH_X40
) (
  input  wire logic                  CLK,                 // 20 MHz clock
  input  wire logic                  NRST,                // sync reset, low
  input  wire logic                  FALL_THROUGH_SELECT, // mode strap
  input  wire logic [1:0]            OFFSET_DEFAULT_SEL,  // offset strap
  input  wire logic [1:0]            BUS_WIDTH_SEL,       // width strap
  input  wire logic                  DDR_SEL,             // rate strap
  input  wire logic                  WRITE_EN_N,          // write enable
  input  wire logic                  WRITE_SELECT_N,      // write select
  input  wire logic [1:0]            WRITE_QUEUE,         // write queue
  input  wire logic                  READ_EN_N,           // read enable
  input  wire logic                  READ_SELECT_N,       // read select
  input  wire logic [1:0]            READ_QUEUE,          // read queue
  output logic                       STORE_STROBE,        // word to storage
  output logic [1:0]                 STORE_QUEUE,         // its queue
  output logic [qft_pkg::NQ-1:0]     FETCH_STROBE,        // word to output
  output logic [qft_pkg::NQ-1:0]     EMPTY_FLAG_N,        // standard empty
  output logic [qft_pkg::NQ-1:0]     FULL_FLAG_N,         // standard full
  output logic [qft_pkg::NQ-1:0]     OUTPUT_READY_N,      // ft output ready
  output logic [qft_pkg::NQ-1:0]     INPUT_READY_N,       // ft input ready
  output logic [qft_pkg::NQ-1:0]     ALMOST_EMPTY_N,      // almost empty
  output logic [qft_pkg::NQ-1:0]     ALMOST_FULL_N,       // almost full
  output logic                       MODE_FALL_THROUGH    // latched mode
);
  import qft_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [NQ-1:0][CNT_W-1:0] cnt;
    logic [NQ-1:0]            or3;
  } qft_top_st_t;

  qft_top_st_t st_r;
  qft_top_st_t st_nxt;

  qft_qcfg_t              qcfg;
  qft_strap_t             straps;
  qft_req_t               wreq;
  qft_req_t               wq;
  logic [NQ-1:0]          wr;
  logic [NQ-1:0]          rd;
  logic [NQ-1:0]          rfetch;
  logic [NQ-1:0]          rfetch_q;
  logic [NQ-1:0]          autofetch;
  logic [NQ-1:0]          room;
  logic [NQ-1:0]          shown;
  logic [NQ-1:0][CNT_W-1:0] cnt_nxt;
  qft_flags_t [NQ-1:0]    raw;
  qft_flags_t [NQ-1:0]    flg2;
  qft_flags_t [NQ-1:0]    fl;
  logic                   wacc;
  logic                   racc;
  logic                   rq_busy;

  // ==========================================================
  // configuration
  assign straps = '{ft: FALL_THROUGH_SELECT, off_sel: OFFSET_DEFAULT_SEL,
                    width_sel: BUS_WIDTH_SEL, ddr: DDR_SEL};

  qft_strap #(
    .BASE_DEPTH (BASE_DEPTH)
  ) u_strap (
    .clk  (CLK),
    .nrst (NRST),
    .pins (straps),
    .qcfg (qcfg)
  );

  assign MODE_FALL_THROUGH = qcfg.ft;

  // ==========================================================
  // write port
  // refusal uses the visible flag; words already in the pipe are
  // dropped at store time if the count has reached capacity
  always_comb begin
    if (qcfg.ft) begin
      wacc = !WRITE_SELECT_N; // R14
    end else begin
      wacc = !WRITE_EN_N && !WRITE_SELECT_N; // R05
    end
    wacc = wacc && !fl[WRITE_QUEUE].full; // R09 R17
  end

  assign wreq = '{valid: wacc, q: WRITE_QUEUE};

  // controls taken on the rising edge only, rate affects depth only
  qft_pipe #(
    .W   (3),
    .S   (DATA_STAGES),
    .RST (3'h0)
  ) u_wpipe (
    .clk  (CLK),
    .nrst (NRST),
    .d    (wreq), // R22
    .q    (wq)    // R23
  );

  assign STORE_STROBE = wq.valid && room[wq.q];
  assign STORE_QUEUE  = wq.q;

  // ==========================================================
  // read port
  assign rq_busy = st_r.cnt[READ_QUEUE] != '0;

  always_comb begin
    if (qcfg.ft) begin
      racc = !READ_SELECT_N && shown[READ_QUEUE] && rq_busy; // R04 R19
    end else begin
      racc = !READ_EN_N && !READ_SELECT_N && rq_busy; // R02 R12
    end
  end

  // ==========================================================
  // per-queue counters and flags
  genvar gi;
  generate
    for (gi = 0; gi < NQ; gi++) begin : g_q
      logic [CNT_W-1:0] c;
      logic [CNT_W-1:0] ae_lim;

      assign wr[gi]   = STORE_STROBE && (wq.q == 2'(gi));
      assign rd[gi]   = racc && (READ_QUEUE == 2'(gi));
      assign room[gi] = st_r.cnt[gi] < qcfg.cap;

      // in fall-through the word on the output is part of the count
      assign c = cnt_nxt[gi];
      assign ae_lim = qcfg.n + (qcfg.ft ? 18'h00002 : 18'h00001); // R07 R15

      assign raw[gi].empty  = c == '0;                      // R06 R12 R19
      assign raw[gi].full   = c >= qcfg.cap;                // R09 R17
      assign raw[gi].aempty = c < ae_lim;                   // R11
      assign raw[gi].afull  = c >= (qcfg.cap - qcfg.m);     // R08 R16

      // flags are registered from the next count, so stage one
      // already reflects the store or read of this cycle
      qft_pipe #(
        .W   (4),
        .S   (FLAG_STAGES),
        .RST (FLAGS_RST) // R25
      ) u_fpipe (
        .clk  (CLK),
        .nrst (NRST),
        .d    (raw[gi]),
        .q    (flg2[gi]) // R13
      );

      always_comb begin
        fl[gi] = flg2[gi];
        if (qcfg.ft) begin
          fl[gi].empty = st_r.or3[gi]; // R20
        end
      end

      assign shown[gi] = !fl[gi].empty;

      // the output word is fetched as the third stage falls,
      // so data and output-ready change on the same edge
      assign autofetch[gi] = qcfg.ft && st_r.or3[gi] && !flg2[gi].empty; // R03

      // a fall-through read pulls the next word only if one is left
      // or one lands in storage in the same cycle
      assign rfetch[gi] = rd[gi] && (!qcfg.ft || (st_r.cnt[gi] > 18'h00001) || wr[gi]);

      assign EMPTY_FLAG_N[gi]   = qcfg.ft ? 1'b1 : !fl[gi].empty;
      assign OUTPUT_READY_N[gi] = qcfg.ft ? fl[gi].empty : 1'b1;
      assign FULL_FLAG_N[gi]    = qcfg.ft ? 1'b1 : !fl[gi].full;  // R10
      assign INPUT_READY_N[gi]  = qcfg.ft ? !fl[gi].full : 1'b1;  // R18
      assign ALMOST_EMPTY_N[gi] = !fl[gi].aempty;
      assign ALMOST_FULL_N[gi]  = !fl[gi].afull;
    end
  endgenerate

  // ==========================================================
  // read data pipeline
  qft_pipe #(
    .W   (NQ),
    .S   (DATA_STAGES),
    .RST ('0)
  ) u_rpipe (
    .clk  (CLK),
    .nrst (NRST),
    .d    (rfetch),
    .q    (rfetch_q) // R23
  );

  assign FETCH_STROBE = rfetch_q | autofetch;

  // ==========================================================
  // counts
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < NQ; i++) begin
      cnt_nxt[i] = st_r.cnt[i] + {{(CNT_W-1){1'b0}}, wr[i]}
                 - {{(CNT_W-1){1'b0}}, rd[i]}; // R24
    end
    if (!NRST) begin
      st_nxt.cnt = '0;    // R25
      st_nxt.or3 = '1;
    end else begin
      st_nxt.cnt = cnt_nxt;
      for (int i = 0; i < NQ; i++) begin
        st_nxt.or3[i] = flg2[i].empty; // R20
      end
    end
  end

  always_ff @(posedge CLK) begin
    st_r <= st_nxt;
  end
endmodule // qft_queue_flags

`default_nettype wire

// ---- qft_pkg.sv ----
// shared constants and carrier types of the queue flag timing block
// assumes one clock domain; straps are static pins sampled around reset
`default_nettype none

package qft_pkg;
  // ==========================================================
  // sizes
  localparam int unsigned NQ           = 4;
  localparam int unsigned CNT_W        = 18;
  localparam int unsigned DATA_STAGES  = 2;
  localparam int unsigned FLAG_STAGES  = 2;
  localparam logic [CNT_W-1:0] BASE_DEPTH_X40 = 18'h02000;

  // ==========================================================
  // default offsets by offset select
  localparam logic [CNT_W-1:0] OFFSET_SEL0 = 18'h00007;
  localparam logic [CNT_W-1:0] OFFSET_SEL1 = 18'h0003f;
  localparam logic [CNT_W-1:0] OFFSET_SEL2 = 18'h0007f;
  localparam logic [CNT_W-1:0] OFFSET_SEL3 = 18'h003ff;

  // bus width select codes
  localparam logic [1:0] WIDTH_X20 = 2'h1;
  localparam logic [1:0] WIDTH_X10 = 2'h2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       ft;
    logic [1:0] off_sel;
    logic [1:0] width_sel;
    logic       ddr;
  } qft_strap_t;

  typedef struct packed {
    logic             ft;
    logic [CNT_W-1:0] n;
    logic [CNT_W-1:0] m;
    logic [CNT_W-1:0] cap;
  } qft_qcfg_t;

  // asserted-high internal flag sense
  typedef struct packed {
    logic empty;
    logic full;
    logic aempty;
    logic afull;
  } qft_flags_t;

  localparam qft_flags_t FLAGS_RST = '{empty: 1'b1, full: 1'b0, aempty: 1'b1, afull: 1'b0};

  typedef struct packed {
    logic       valid;
    logic [1:0] q;
  } qft_req_t;
endpackage

`default_nettype wire

// ---- qft_pipe.sv ----
// register pipeline of S stages, W bits wide, with a reset pattern
// assumes synchronous active-low reset on the same clock
`default_nettype none

module qft_pipe #(
  parameter int unsigned W   = 1,
  parameter int unsigned S   = 2,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,   // clock
  input  wire logic         nrst,  // sync reset, low
  input  wire logic [W-1:0] d,     // stage input
  output logic      [W-1:0] q      // last stage
);
  import qft_pkg::*;

  typedef struct packed {
    logic [S-1:0][W-1:0] stg;
  } qft_pipe_st_t;

  qft_pipe_st_t st_r;
  qft_pipe_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!nrst) begin
      st_nxt.stg = {S{RST}};
    end else begin
      st_nxt.stg[0] = d;
      for (int i = 1; i < S; i++) begin
        st_nxt.stg[i] = st_r.stg[i-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign q = st_r.stg[S-1];
endmodule // qft_pipe

`default_nettype wire

// ---- qft_strap.sv ----
// strap synchroniser and reset-time configuration latch
// assumes straps are static and reset is held at least three clocks
`default_nettype none

module qft_strap #(
  parameter logic [qft_pkg::CNT_W-1:0] BASE_DEPTH = qft_pkg::BASE_DEPTH_X40
) (
  input  wire logic               clk,    // clock
  input  wire logic               nrst,   // sync reset, low
  input  wire qft_pkg::qft_strap_t pins,  // raw strap pins
  output qft_pkg::qft_qcfg_t      qcfg    // latched queue config
);
  import qft_pkg::*;

  typedef struct packed {
    qft_strap_t syn1;
    qft_strap_t syn2;
    qft_qcfg_t  cfg;
  } qft_strap_st_t;

  qft_strap_st_t st_r;
  qft_strap_st_t st_nxt;

  always_comb begin
    logic [CNT_W-1:0] dep;
    logic [CNT_W-1:0] off;
    dep = BASE_DEPTH;
    off = OFFSET_SEL0;
    st_nxt = st_r;
    st_nxt.syn1 = pins;
    st_nxt.syn2 = st_r.syn1;
    case (st_r.syn2.width_sel)
      WIDTH_X20: dep = BASE_DEPTH << 1;
      WIDTH_X10: dep = BASE_DEPTH << 2;
      default:   dep = BASE_DEPTH;
    endcase
    if (st_r.syn2.ddr) begin
      dep = dep >> 1;
    end
    case (st_r.syn2.off_sel)
      2'h0:    off = OFFSET_SEL0; // R21
      2'h1:    off = OFFSET_SEL1;
      2'h2:    off = OFFSET_SEL2;
      2'h3:    off = OFFSET_SEL3;
      default: off = OFFSET_SEL0;
    endcase
    // config follows the straps only while reset is low
    if (!nrst) begin
      st_nxt.cfg.ft  = st_r.syn2.ft; // R01
      st_nxt.cfg.n   = off;
      st_nxt.cfg.m   = off;
      st_nxt.cfg.cap = dep + {{(CNT_W-1){1'b0}}, st_r.syn2.ft}; // R24
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign qcfg = st_r.cfg;
endmodule // qft_strap

`default_nettype wire

// ---- qft_queue_flags_sva.sv ----
// assertions on the ports of the queue flag timing block
// assumes one clock CLK and a synchronous active-low NRST
`default_nettype none

module qft_queue_flags_sva (
  input wire logic                   CLK,              // clock
  input wire logic                   NRST,             // reset
  input wire logic                   WRITE_EN_N,       // write enable
  input wire logic                   WRITE_SELECT_N,   // write select
  input wire logic [1:0]             WRITE_QUEUE,      // write queue
  input wire logic                   READ_EN_N,        // read enable
  input wire logic                   READ_SELECT_N,    // read select
  input wire logic [1:0]             READ_QUEUE,       // read queue
  input wire logic                   STORE_STROBE,     // store pulse
  input wire logic [1:0]             STORE_QUEUE,      // store queue
  input wire logic [qft_pkg::NQ-1:0] FETCH_STROBE,     // fetch pulses
  input wire logic [qft_pkg::NQ-1:0] EMPTY_FLAG_N,     // empty
  input wire logic [qft_pkg::NQ-1:0] FULL_FLAG_N,      // full
  input wire logic [qft_pkg::NQ-1:0] OUTPUT_READY_N,   // output ready
  input wire logic [qft_pkg::NQ-1:0] INPUT_READY_N,    // input ready
  input wire logic                   MODE_FALL_THROUGH // mode
);
  import qft_pkg::*;
  logic       wr_req;
  logic       rd_req;
  logic [1:0] rst_cnt = 2'h0;
  // enable only counts in standard mode
  assign wr_req = !WRITE_SELECT_N && (MODE_FALL_THROUGH || !WRITE_EN_N);
  assign rd_req = !READ_SELECT_N && (MODE_FALL_THROUGH || !READ_EN_N);

  // reset edges seen so far; the strap latch needs three to settle
  always_ff @(posedge CLK) begin
    if (NRST) begin
      rst_cnt <= 2'h0;
    end else if (rst_cnt != 2'h3) begin
      rst_cnt <= rst_cnt + 2'h1;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  // ==========================================================
  // properties
  sequence s_wr_full;
    wr_req && !(FULL_FLAG_N[WRITE_QUEUE] && INPUT_READY_N[WRITE_QUEUE]);
  endsequence
  property p_store;
    STORE_STROBE |-> $past(wr_req, 2) && STORE_QUEUE == $past(WRITE_QUEUE, 2);
  endproperty
  a_store: assert property (p_store) else $error("store timing");
  property p_refuse;
    s_wr_full |-> ##2 !STORE_STROBE;
  endproperty
  a_refuse: assert property (p_refuse) else $error("write into full");
  property p_fetch;
    |FETCH_STROBE && !MODE_FALL_THROUGH |->
      $past(rd_req, 2) && FETCH_STROBE == (4'h1 << $past(READ_QUEUE, 2));
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch timing");
  property p_ef;
    |(EMPTY_FLAG_N & ~$past(EMPTY_FLAG_N)) && !MODE_FALL_THROUGH |->
      $past(STORE_STROBE, 2) && EMPTY_FLAG_N[$past(STORE_QUEUE, 2)];
  endproperty
  a_ef: assert property (p_ef) else $error("empty flag timing");
  property p_ff;
    |(FULL_FLAG_N & ~$past(FULL_FLAG_N)) |->
      $past(rd_req, 2) && FULL_FLAG_N[$past(READ_QUEUE, 2)];
  endproperty
  a_ff: assert property (p_ff) else $error("full flag timing");
  property p_ir;
    |(INPUT_READY_N & ~$past(INPUT_READY_N)) |->
      $past(rd_req, 2) && INPUT_READY_N[$past(READ_QUEUE, 2)];
  endproperty
  a_ir: assert property (p_ir) else $error("input ready timing");
  property p_or;
    |(~OUTPUT_READY_N & $past(OUTPUT_READY_N)) |->
      $past(STORE_STROBE, 3) && !OUTPUT_READY_N[$past(STORE_QUEUE, 3)];
  endproperty
  a_or: assert property (p_or) else $error("output ready timing");
  property p_mode;
    $past(NRST) |-> $stable(MODE_FALL_THROUGH);
  endproperty
  a_mode: assert property (p_mode) else $error("mode changed");
  property p_unused;
    $past(NRST) && $past(NRST, 2) |-> MODE_FALL_THROUGH ?
      (EMPTY_FLAG_N & FULL_FLAG_N) == '1 : (OUTPUT_READY_N & INPUT_READY_N) == '1;
  endproperty
  a_unused: assert property (p_unused) else $error("idle flag set");
  // reset itself is the cause here, so no disable
  property p_rst;
    disable iff (1'h0) !NRST && rst_cnt == 2'h3 |=>
      (MODE_FALL_THROUGH || EMPTY_FLAG_N == '0) && FULL_FLAG_N == '1 &&
      OUTPUT_READY_N == '1 && INPUT_READY_N == '1 && FETCH_STROBE == '0 &&
      !STORE_STROBE;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule // qft_queue_flags_sva

bind qft_queue_flags qft_queue_flags_sva qft_queue_flags_sva_i (
  .CLK, .NRST, .WRITE_EN_N, .WRITE_SELECT_N, .WRITE_QUEUE, .READ_EN_N,
  .READ_SELECT_N, .READ_QUEUE, .STORE_STROBE, .STORE_QUEUE, .FETCH_STROBE,
  .EMPTY_FLAG_N, .FULL_FLAG_N, .OUTPUT_READY_N, .INPUT_READY_N, .MODE_FALL_THROUGH
);

`default_nettype wire

// ---- qft_store_model.sv ----
// storage side model: counts words stored and fetched per queue
// assumes strobes from qft_queue_flags on the same clock
`default_nettype none

module qft_store_model (
  input  wire logic                   clk,          // clock
  input  wire logic                   nrst,         // sync reset, low
  input  wire logic                   store_strobe, // word stored
  input  wire logic [1:0]             store_queue,  // its queue
  input  wire logic [qft_pkg::NQ-1:0] fetch_strobe, // word fetched
  output int                          stored [4],   // stored per queue
  output int                          fetched [4]   // fetched per queue
);
  import qft_pkg::*;
  always_ff @(posedge clk) begin
    for (int i = 0; i < NQ; i++) begin
      if (!nrst) begin
        stored[i]  <= 0;
        fetched[i] <= 0;
      end else begin
        stored[i]  <= stored[i] + int'(store_strobe && store_queue == i);
        fetched[i] <= fetched[i] + int'(fetch_strobe[i]);
      end
    end
  end
endmodule // qft_store_model

`default_nettype wire

// ---- qft_queue_flags_tb.sv ----
// self-checking bench of the queue flag timing block
// assumes package, design, checker and storage model compile first
`default_nettype none

module qft_queue_flags_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import qft_pkg::*;
  // small depth keeps fills short; offsets stay at n = m = 7
  localparam logic [CNT_W-1:0] DEPTH = 18'h00018;
  localparam int D = int'(DEPTH);
  localparam int N = int'(OFFSET_SEL0);

  logic          CLK;
  logic          NRST;
  qft_strap_t    strap;
  logic          wen_n;
  logic          wsel_n;
  logic [1:0]    wq;
  logic          ren_n;
  logic          rsel_n;
  logic [1:0]    rq;
  logic          st_stb;
  logic [1:0]    st_q;
  logic [NQ-1:0] fetch;
  logic [NQ-1:0] ef;
  logic [NQ-1:0] ff;
  logic [NQ-1:0] orn;
  logic [NQ-1:0] irn;
  logic [NQ-1:0] ae;
  logic [NQ-1:0] af;
  logic          mode;
  int            stored [4];
  int            fetched [4];
  int            err_count;
  int            comparisons;

  qft_queue_flags #(.BASE_DEPTH(DEPTH)) qft_queue_flags_i (
    .CLK, .NRST, .FALL_THROUGH_SELECT(strap.ft), .OFFSET_DEFAULT_SEL(strap.off_sel),
    .BUS_WIDTH_SEL(strap.width_sel), .DDR_SEL(strap.ddr), .WRITE_EN_N(wen_n),
    .WRITE_SELECT_N(wsel_n), .WRITE_QUEUE(wq), .READ_EN_N(ren_n), .READ_SELECT_N(rsel_n),
    .READ_QUEUE(rq), .STORE_STROBE(st_stb), .STORE_QUEUE(st_q), .FETCH_STROBE(fetch),
    .EMPTY_FLAG_N(ef), .FULL_FLAG_N(ff), .OUTPUT_READY_N(orn), .INPUT_READY_N(irn),
    .ALMOST_EMPTY_N(ae), .ALMOST_FULL_N(af), .MODE_FALL_THROUGH(mode)
  );
  qft_store_model qft_store_model_i (
    .clk(CLK), .nrst(NRST), .store_strobe(st_stb), .store_queue(st_q),
    .fetch_strobe(fetch), .stored(stored), .fetched(fetched)
  );

  initial begin
    CLK = 1'h0;
    forever #25 CLK = ~CLK;
  end

  // ==========================================================
  // helpers
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s: expected %0h, seen %0h", name, exp, seen);
    end
  endtask

  task automatic do_reset(logic ft, logic [1:0] width = 2'h0, logic ddr = 1'h0);
    @(posedge CLK);
    NRST  <= 1'h0;
    strap <= '{ft: ft, off_sel: 2'h0, width_sel: width, ddr: ddr};
    repeat (8) @(posedge CLK);
    NRST <= 1'h1;
    repeat (2) @(posedge CLK);
    #1;
  endtask

  task automatic xfer(logic rd, logic [1:0] q, int k, logic en_n);
    repeat (k) begin
      @(posedge CLK);
      if (rd) begin
        rsel_n <= 1'h0;
        ren_n  <= en_n;
        rq     <= q;
      end else begin
        wsel_n <= 1'h0;
        wen_n  <= en_n;
        wq     <= q;
      end
    end
    @(posedge CLK);
    {wsel_n, wen_n, rsel_n, ren_n} <= 4'hf;
    // long enough for the triple-staged ready flag
    repeat (7) @(posedge CLK);
    #1;
  endtask

  task automatic give_verdict;
    $display("comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_std_fill;
    do_reset(1'h0);
    check("mode", mode, 1'h0);
    check("empty", ef, 4'h0);
    check("almost full", af, 4'hf);
    xfer(0, 1, 1, 1);
    check("stored", stored[1], 0);
    xfer(0, 1, N, 0);
    check("empty", ef, 4'h2);
    check("almost empty", ae, 4'h0);
    xfer(0, 1, 1, 0);
    check("almost empty", ae, 4'h2);
    xfer(0, 1, D - 2 * N - 2, 0);
    check("almost full", af, 4'hf);
    xfer(0, 1, 1, 0);
    check("almost full", af, 4'hd);
    xfer(0, 1, N, 0);
    check("full", ff, 4'hd);
    xfer(0, 1, 2, 0);
    check("stored", stored[1], D);
  endtask

  task automatic t_std_drain;
    xfer(1, 1, 1, 0);
    check("full", ff, 4'hf);
    xfer(1, 1, 1, 1);
    check("fetched", fetched[1], 1);
    xfer(1, 1, N, 0);
    check("almost full", af, 4'hf);
    xfer(1, 1, D - 1 - 2 * N, 0);
    check("almost empty", ae, 4'h0);
    xfer(1, 1, N, 0);
    check("empty", ef, 4'h0);
    xfer(1, 1, 2, 0);
    check("fetched", fetched[1], D);
  endtask

  task automatic t_fall_through;
    do_reset(1'h1);
    check("mode", mode, 1'h1);
    xfer(0, 2, 1, 1);
    check("output ready", orn, 4'hb);
    check("fetched", fetched[2], 1);
    xfer(0, 2, N, 1);
    check("almost empty", ae, 4'h0);
    xfer(0, 2, 1, 1);
    check("almost empty", ae, 4'h4);
    xfer(0, 2, D - 2 * N - 2, 1);
    check("almost full", af, 4'hf);
    xfer(0, 2, 1, 1);
    check("almost full", af, 4'hb);
    xfer(0, 2, N, 1);
    check("input ready", irn, 4'hb);
    xfer(0, 2, 1, 1);
    check("stored", stored[2], D + 1);
    xfer(1, 2, 1, 1);
    check("input ready", irn, 4'hf);
    xfer(1, 2, D, 1);
    check("output ready", orn, 4'hf);
    xfer(1, 2, 1, 1);
    check("fetched", fetched[2], D + 1);
  endtask

  // narrow bus at double rate: four times then half the base depth
  task automatic t_depth_cfg;
    do_reset(1'h0, WIDTH_X10, 1'h1);
    check("mode", mode, 1'h0);
    xfer(0, 3, 2 * D - 1, 0);
    check("full", ff, 4'hf);
    check("almost full", af, 4'h7);
    // the second write is still in the pipe when the count tops out
    xfer(0, 3, 2, 0);
    check("full", ff, 4'h7);
    check("stored", stored[3], 2 * D);
  endtask

  initial begin
    NRST = 1'h0;
    strap = '0;
    {wsel_n, wen_n, rsel_n, ren_n} = 4'hf;
    wq = 2'h0;
    rq = 2'h0;
    err_count = 0;
    comparisons = 0;
    t_std_fill();
    t_std_drain();
    t_fall_through();
    t_depth_cfg();
    give_verdict();
  end

  initial begin
    repeat (4000) @(posedge CLK);
    err_count++;
    give_verdict();
  end
endmodule // qft_queue_flags_tb

`default_nettype wire
